// file: core/dlfc_engine.sv
`timescale 1ns/1ps
// Functional notes
// - Flag 0 shows base A and draws to B; flag 1 swaps the roles.
// - A new display base takes effect only after the next internal update.
// - Each internal update sets the frame done flag once cleared by host.
// - Register-write command loads start pointer, start valid and display bases.
// - Writing 1 to render_go starts execution from the draw start address.
// - Offset-set command loads the local offset absolutely.
// - Offset-shift command adds a signed value to the local offset.
// - Move sets current pointer to parameter plus local offset.
// - Relative-pointer command adds a displacement to the current pointer.
// - Non-relative commands may overwrite the current pointer as scratch.
// - A 16-word source buffer holds fetched source data.
// - Buffer refills 32 bytes when a new 16-word block is addressed.
// - Wrap mode repeats the source from its start; otherwise no repeat.
// - Work-clear command zeroes the whole work area.
// - Work-fill command draws a polygon shape into the work area.
// - Quad fill with work-reference draws only pixels masked by work area.
// - Jump redirects fetch so embedded source data is skipped.
// - Textured quad with inline flag takes its source from the list.
// - render_go clears to 0 when execution ends.
module dlfc_engine
  import dlfc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic mem_req,
  output logic [MEM_AW-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [MEM_DW-1:0] mem_rdata,
  input wire logic frame_update,
  output logic draw_valid,
  input wire logic draw_ready,
  output dlfc_draw_s draw_req,
  input wire logic draw_done,
  input wire logic src_valid,
  input wire logic [15:0] src_index,
  output logic src_ready,
  output logic [MEM_DW-1:0] src_data,
  output logic [MEM_AW-1:0] display_addr
);

  function automatic logic [3:0] param_count(input logic [3:0] op);
    unique case (op)
      OP_REG_WRITE: param_count = 4'd3;
      OP_OFFSET_SET, OP_OFFSET_SHIFT, OP_MOVE, OP_REL_POINTER, OP_JUMP: param_count = 4'd2;
      OP_WORK_FILL, OP_QUAD_FILL: param_count = 4'd4;
      OP_QUAD_TEXTURE, OP_QUAD_PATTERN: param_count = 4'd7;
      default: param_count = 4'd0;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction

  logic render_go_q;
  logic swap_mode_q;
  logic frame_done_q;
  logic buf_sel_q;
  logic [MEM_AW-1:0] base_a_q;
  logic [MEM_AW-1:0] base_b_q;
  logic [MEM_AW-1:0] start_ptr_q;
  logic start_valid_q;
  logic [MEM_AW-1:0] disp_addr_q;
  logic [15:0] lofs_x_q;
  logic [15:0] lofs_y_q;
  logic [15:0] cp_x_q;
  logic [15:0] cp_y_q;
  logic [MEM_AW-1:0] pc_q;
  dlfc_ex_e ex_q;
  logic [MEM_DW-1:0] cmd_q;
  logic [MEM_DW-1:0] prm_q [PARAM_MAX];
  logic [3:0] pcnt_q;
  dlfc_draw_s draw_q;
  logic wrap_q;
  logic [15:0] src_len_q;
  dlfc_sb_e sb_q;
  logic [MEM_DW-1:0] sbuf_q [SRC_WORDS];
  logic [MEM_AW-SRC_IW-1:0] tag_q;
  logic tag_ok_q;
  logic [SRC_IW-1:0] fcnt_q;
  logic [MEM_DW-1:0] src_data_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  logic wr_go;
  logic go_start;
  logic ex_mem;
  logic sb_mem;
  logic exec_now;
  logic [3:0] op_now;
  logic [15:0] src_off;
  logic [MEM_AW-1:0] src_addr;
  logic src_hit;
  logic [MEM_AW-1:0] p_hilo;
  logic buf_sel_next;

  assign op_now = cmd_q[15:12];
  assign exec_now = (ex_q == EX_EXEC);
  assign p_hilo = {prm_q[1][7:0], prm_q[2]};

  // AXI4-Lite write channel takes address and data together.
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_wready = s_axi_awready;
  assign wr_go = s_axi_awready;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= (hit(s_axi_awaddr, OFS_SYSCTL) || hit(s_axi_awaddr, OFS_STATUS) ||
                  hit(s_axi_awaddr, OFS_BASE_A) || hit(s_axi_awaddr, OFS_BASE_B) ||
                  hit(s_axi_awaddr, OFS_START_PTR) || hit(s_axi_awaddr, OFS_START_VALID))
                 ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h00000000;
      if (hit(s_axi_araddr, OFS_SYSCTL)) begin
        rdata_q[BIT_RENDER_GO] <= render_go_q;
        rdata_q[BIT_SWAP_MODE] <= swap_mode_q;
      end else if (hit(s_axi_araddr, OFS_STATUS)) begin
        rdata_q[BIT_FRAME_DONE] <= frame_done_q;
        rdata_q[BIT_BUF_SEL] <= buf_sel_q;
        rdata_q[BIT_BUSY] <= (ex_q != EX_IDLE);
      end else if (hit(s_axi_araddr, OFS_BASE_A)) begin
        rdata_q[MEM_AW-1:0] <= base_a_q;
      end else if (hit(s_axi_araddr, OFS_BASE_B)) begin
        rdata_q[MEM_AW-1:0] <= base_b_q;
      end else if (hit(s_axi_araddr, OFS_START_PTR)) begin
        rdata_q[MEM_AW-1:0] <= start_ptr_q;
      end else if (hit(s_axi_araddr, OFS_START_VALID)) begin
        rdata_q[0] <= start_valid_q;
      end else if (hit(s_axi_araddr, OFS_LOCAL_OFS)) begin
        rdata_q <= {lofs_y_q, lofs_x_q};
      end else if (hit(s_axi_araddr, OFS_CUR_PTR)) begin
        rdata_q <= {cp_y_q, cp_x_q};
      end else if (hit(s_axi_araddr, OFS_DISP_ADDR)) begin
        rdata_q[MEM_AW-1:0] <= disp_addr_q;
      end else begin
        rresp_q <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign go_start = wr_go && hit(s_axi_awaddr, OFS_SYSCTL) && s_axi_wstrb[0] &&
                    s_axi_wdata[BIT_RENDER_GO] && !render_go_q;

  // A start while running is ignored; the engine alone ends a run.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      render_go_q <= 1'b0;
      swap_mode_q <= 1'b0;
    end else begin
      if (go_start) begin
        render_go_q <= 1'b1;
      end else if (exec_now && op_now == OP_END) begin
        render_go_q <= 1'b0;
      end
      if (wr_go && hit(s_axi_awaddr, OFS_SYSCTL) && s_axi_wstrb[0]) begin
        swap_mode_q <= s_axi_wdata[BIT_SWAP_MODE];
      end
    end
  end

  assign buf_sel_next = (swap_mode_q && !render_go_q) ? !buf_sel_q : buf_sel_q;

  // Internal update: the flag may swap, then the display base is latched.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_sel_q <= 1'b0;
      disp_addr_q <= RST_ADDR;
      frame_done_q <= 1'b0;
    end else begin
      if (frame_update) begin
        buf_sel_q <= buf_sel_next;
        disp_addr_q <= buf_sel_next ? base_b_q : base_a_q;
      end else if (wr_go && hit(s_axi_awaddr, OFS_STATUS) && s_axi_wstrb[0]) begin
        buf_sel_q <= s_axi_wdata[BIT_BUF_SEL];
      end
      if (frame_update) begin
        frame_done_q <= 1'b1;
      end else if (wr_go && hit(s_axi_awaddr, OFS_STATUS) && s_axi_wstrb[0] &&
                   s_axi_wdata[BIT_FRAME_DONE]) begin
        frame_done_q <= 1'b0;
      end
    end
  end

  assign display_addr = disp_addr_q;

  // Host writes take priority over a register-write command in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_a_q <= RST_ADDR;
      base_b_q <= RST_ADDR;
      start_ptr_q <= RST_ADDR;
      start_valid_q <= 1'b0;
    end else if (wr_go) begin
      if (hit(s_axi_awaddr, OFS_BASE_A)) begin
        base_a_q <= s_axi_wdata[MEM_AW-1:0];
      end
      if (hit(s_axi_awaddr, OFS_BASE_B)) begin
        base_b_q <= s_axi_wdata[MEM_AW-1:0];
      end
      if (hit(s_axi_awaddr, OFS_START_PTR)) begin
        start_ptr_q <= s_axi_wdata[MEM_AW-1:0];
      end
      if (hit(s_axi_awaddr, OFS_START_VALID)) begin
        start_valid_q <= s_axi_wdata[0];
      end
    end else if (exec_now && op_now == OP_REG_WRITE) begin
      unique case (prm_q[0][1:0])
        2'd0: base_a_q <= p_hilo;
        2'd1: base_b_q <= p_hilo;
        2'd2: start_ptr_q <= p_hilo;
        2'd3: start_valid_q <= prm_q[2][0];
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lofs_x_q <= RST_COORD;
      lofs_y_q <= RST_COORD;
    end else if (exec_now && op_now == OP_OFFSET_SET) begin
      lofs_x_q <= prm_q[0];
      lofs_y_q <= prm_q[1];
    end else if (exec_now && op_now == OP_OFFSET_SHIFT) begin
      lofs_x_q <= lofs_x_q + prm_q[0];
      lofs_y_q <= lofs_y_q + prm_q[1];
    end
  end

  // Drawing commands except work-clear leave their last vertex in the current pointer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cp_x_q <= RST_COORD;
      cp_y_q <= RST_COORD;
    end else if (exec_now) begin
      if (op_now == OP_MOVE) begin
        cp_x_q <= prm_q[0] + lofs_x_q;
        cp_y_q <= prm_q[1] + lofs_y_q;
      end else if (op_now == OP_REL_POINTER) begin
        cp_x_q <= cp_x_q + prm_q[0];
        cp_y_q <= cp_y_q + prm_q[1];
      end else if (op_now >= OP_WORK_FILL && op_now <= OP_QUAD_PATTERN) begin
        cp_x_q <= prm_q[2];
        cp_y_q <= prm_q[3];
      end
    end
  end

  assign ex_mem = (ex_q == EX_FETCH) || (ex_q == EX_PARAM);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ex_q <= EX_IDLE;
      pc_q <= RST_ADDR;
      cmd_q <= 16'h0000;
      pcnt_q <= 4'd0;
    end else begin
      unique case (ex_q)
        EX_IDLE: begin
          if (go_start) begin
            pc_q <= start_ptr_q;
            ex_q <= EX_FETCH;
          end
        end
        EX_FETCH: begin
          if (mem_ack) begin
            cmd_q <= mem_rdata;
            pc_q <= pc_q + 24'd1;
            pcnt_q <= 4'd0;
            ex_q <= (param_count(mem_rdata[15:12]) == 4'd0) ? EX_EXEC : EX_PARAM;
          end
        end
        EX_PARAM: begin
          if (mem_ack) begin
            pc_q <= pc_q + 24'd1;
            pcnt_q <= pcnt_q + 4'd1;
            if (pcnt_q == param_count(op_now) - 4'd1) begin
              ex_q <= EX_EXEC;
            end
          end
        end
        EX_EXEC: begin
          if (op_now == OP_END) begin
            ex_q <= EX_IDLE;
          end else if (op_now == OP_JUMP) begin
            pc_q <= {prm_q[0][7:0], prm_q[1]};
            ex_q <= EX_FETCH;
          end else if (op_now >= OP_WORK_CLEAR && op_now <= OP_QUAD_PATTERN) begin
            ex_q <= EX_DRAW;
          end else begin
            ex_q <= EX_FETCH;
          end
        end
        EX_DRAW: begin
          if (draw_ready) begin
            ex_q <= EX_DWAIT;
          end
        end
        EX_DWAIT: begin
          if (draw_done) begin
            ex_q <= EX_FETCH;
          end
        end
        default: ex_q <= EX_IDLE;
      endcase
    end
  end

  generate
    for (genvar i = 0; i < PARAM_MAX; i++) begin : g_prm
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          prm_q[i] <= 16'h0000;
        end else if (ex_q == EX_PARAM && mem_ack && pcnt_q == 4'(i)) begin
          prm_q[i] <= mem_rdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      draw_q <= '0;
      wrap_q <= 1'b0;
      src_len_q <= 16'h0000;
    end else if (exec_now) begin
      draw_q.op <= dlfc_op_e'(op_now);
      draw_q.to_work <= (op_now == OP_WORK_CLEAR) || (op_now == OP_WORK_FILL);
      draw_q.work_ref <= (op_now == OP_QUAD_FILL) && cmd_q[ATTR_WORK_REF];
      draw_q.use_src <= (op_now == OP_QUAD_TEXTURE) || (op_now == OP_QUAD_PATTERN);
      draw_q.dest_base <= buf_sel_q ? base_a_q : base_b_q;
      draw_q.x0 <= (op_now == OP_WORK_CLEAR) ? 16'h0000 : prm_q[0];
      draw_q.y0 <= (op_now == OP_WORK_CLEAR) ? 16'h0000 : prm_q[1];
      draw_q.x1 <= (op_now == OP_WORK_CLEAR) ? 16'hFFFF : prm_q[2];
      draw_q.y1 <= (op_now == OP_WORK_CLEAR) ? 16'hFFFF : prm_q[3];
      if (op_now == OP_QUAD_TEXTURE && cmd_q[ATTR_INLINE]) begin
        draw_q.src_start <= pc_q;
      end else begin
        draw_q.src_start <= {prm_q[4][7:0], prm_q[5]};
      end
      wrap_q <= cmd_q[ATTR_WRAP];
      src_len_q <= prm_q[6];
    end
  end

  assign draw_valid = (ex_q == EX_DRAW);
  assign draw_req = draw_q;

  // Wrap repeats the pattern every source length words.
  assign src_off = (wrap_q && |src_len_q) ? (src_index % src_len_q) : src_index;
  assign src_addr = draw_q.src_start + {8'h00, src_off};
  assign src_hit = tag_ok_q && (tag_q == src_addr[MEM_AW-1:SRC_IW]);
  assign sb_mem = (sb_q == SB_FILL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sb_q <= SB_IDLE;
      tag_q <= '0;
      tag_ok_q <= 1'b0;
      fcnt_q <= '0;
      src_data_q <= 16'h0000;
    end else begin
      unique case (sb_q)
        SB_IDLE: begin
          if (exec_now) begin
            tag_ok_q <= 1'b0;
          end else if (src_valid && ex_q == EX_DWAIT) begin
            if (src_hit) begin
              src_data_q <= sbuf_q[src_addr[SRC_IW-1:0]];
              sb_q <= SB_OUT;
            end else begin
              tag_q <= src_addr[MEM_AW-1:SRC_IW];
              tag_ok_q <= 1'b0;
              fcnt_q <= '0;
              sb_q <= SB_FILL;
            end
          end
        end
        SB_FILL: begin
          if (mem_ack) begin
            fcnt_q <= fcnt_q + 4'd1;
            if (fcnt_q == 4'(SRC_WORDS - 1)) begin
              tag_ok_q <= 1'b1;
              sb_q <= SB_IDLE;
            end
          end
        end
        SB_OUT: sb_q <= SB_IDLE;
        default: sb_q <= SB_IDLE;
      endcase
    end
  end

  generate
    for (genvar j = 0; j < SRC_WORDS; j++) begin : g_sbuf
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sbuf_q[j] <= 16'h0000;
        end else if (sb_mem && mem_ack && fcnt_q == 4'(j)) begin
          sbuf_q[j] <= mem_rdata;
        end
      end
    end
  endgenerate

  assign src_ready = (sb_q == SB_OUT);
  assign src_data = src_data_q;
  assign mem_req = ex_mem || sb_mem;
  assign mem_addr = sb_mem ? {tag_q, fcnt_q} : pc_q;

endmodule

// file: core/dlfc_pkg.sv
package dlfc_pkg;
  localparam int MEM_AW = 24;
  localparam int MEM_DW = 16;
  localparam int SRC_WORDS = 16;
  localparam int SRC_IW = 4;
  localparam int PARAM_MAX = 8;
  localparam logic [7:0] OFS_SYSCTL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_BASE_A = 8'h08;
  localparam logic [7:0] OFS_BASE_B = 8'h0C;
  localparam logic [7:0] OFS_START_PTR = 8'h10;
  localparam logic [7:0] OFS_START_VALID = 8'h14;
  localparam logic [7:0] OFS_LOCAL_OFS = 8'h18;
  localparam logic [7:0] OFS_CUR_PTR = 8'h1C;
  localparam logic [7:0] OFS_DISP_ADDR = 8'h20;
  localparam int BIT_RENDER_GO = 0;
  localparam int BIT_SWAP_MODE = 1;
  localparam int BIT_FRAME_DONE = 0;
  localparam int BIT_BUF_SEL = 1;
  localparam int BIT_BUSY = 2;
  localparam logic [MEM_AW-1:0] RST_ADDR = 24'h000000;
  localparam logic [15:0] RST_COORD = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int ATTR_WORK_REF = 0;
  localparam int ATTR_INLINE = 1;
  localparam int ATTR_WRAP = 2;

  typedef enum logic [3:0] {
    OP_END = 4'h0,
    OP_REG_WRITE = 4'h1,
    OP_OFFSET_SET = 4'h2,
    OP_OFFSET_SHIFT = 4'h3,
    OP_MOVE = 4'h4,
    OP_REL_POINTER = 4'h5,
    OP_JUMP = 4'h6,
    OP_WORK_CLEAR = 4'h7,
    OP_WORK_FILL = 4'h8,
    OP_QUAD_FILL = 4'h9,
    OP_QUAD_TEXTURE = 4'hA,
    OP_QUAD_PATTERN = 4'hB
  } dlfc_op_e;

  typedef enum logic [2:0] {
    EX_IDLE = 3'h0,
    EX_FETCH = 3'h1,
    EX_PARAM = 3'h2,
    EX_EXEC = 3'h3,
    EX_DRAW = 3'h4,
    EX_DWAIT = 3'h5
  } dlfc_ex_e;

  typedef enum logic [1:0] {
    SB_IDLE = 2'h0,
    SB_FILL = 2'h1,
    SB_OUT = 2'h2
  } dlfc_sb_e;

  typedef struct packed {
    dlfc_op_e op;
    logic to_work;
    logic work_ref;
    logic use_src;
    logic [MEM_AW-1:0] dest_base;
    logic [15:0] x0;
    logic [15:0] y0;
    logic [15:0] x1;
    logic [15:0] y1;
    logic [MEM_AW-1:0] src_start;
  } dlfc_draw_s;
endpackage

// file: verif/display_list_frame_control_test.sv
`timescale 1ns/1ps
module display_list_frame_control_test;
  import dlfc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, frame_update = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic mem_req, mem_ack, draw_valid, draw_ready, draw_done, src_valid, src_ready;
  logic [MEM_AW-1:0] mem_addr, display_addr;
  logic [MEM_DW-1:0] mem_rdata, src_data;
  logic [15:0] src_index;
  dlfc_draw_s draw_req;
  logic [15:0] q [$];
  int error_cnt = 0;
  int n_tests = 0;
  always #50 aclk = ~aclk;
  dlfc_engine uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .frame_update, .draw_valid,
    .draw_ready, .draw_req, .draw_done, .src_valid, .src_index, .src_ready, .src_data,
    .display_addr);
  dlfc_far_model mdl (.aclk, .aresetn, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .draw_valid,
    .draw_ready, .draw_req, .draw_done, .src_valid, .src_index, .src_ready, .src_data);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic stall();
    error_cnt++;
    $display("[FAIL] handshake expected answer seen none");
    wrap_up();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (!(s_axi_awready && s_axi_wready) && k < 50);
    if (!(s_axi_awready && s_axi_wready)) stall();
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (!s_axi_bvalid && k < 50);
    if (!s_axi_bvalid) stall();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (!s_axi_arready && k < 50);
    if (!s_axi_arready) stall();
    s_axi_arvalid <= 1'b0;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (!s_axi_rvalid && k < 50);
    if (!s_axi_rvalid) stall();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, rsp);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, rd, rsp);
    chk(nm, rd, exp);
  endtask

  task automatic pulse();
    @(posedge aclk);
    frame_update <= 1'b1;
    @(posedge aclk);
    frame_update <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic put(input int a);
    foreach (q[i]) mdl.mem[a + i] = q[i];
  endtask

  task automatic run(input logic [23:0] p);
    int k;
    wr(OFS_START_PTR, {8'h00, p});
    rd = {16'h0000, mdl.mem[p[7:0]]};
    wr(OFS_SYSCTL, 32'h1);
    k = 0;
    do begin
      axi_rd(OFS_SYSCTL, rd, rsp);
      k++;
    end while (rd[0] !== 1'b0 && k < 100);
    chk("go_cleared", rd, 32'h0);
    if (rd[0] !== 1'b0) stall();
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("sysctl_reset", OFS_SYSCTL, 32'h0);
    rchk("status_reset", OFS_STATUS, 32'h0);
    axi_wr(8'h40, 32'h1, rsp);
    chk("unmapped_bresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    axi_rd(8'h44, rd, rsp);
    chk("unmapped_read", {rd[29:0], rsp}, {30'h0, RESP_SLVERR});
    wr(OFS_BASE_A, 32'h111);
    wr(OFS_BASE_B, 32'h222);
    chk("disp_before_update", {8'h00, display_addr}, 32'h0);
    pulse();
    chk("disp_flag0", {8'h00, display_addr}, 32'h111);
    rchk("frame_done_set", OFS_STATUS, 32'h1);
    wr(OFS_STATUS, 32'h3);
    rchk("frame_done_clr", OFS_STATUS, 32'h2);
    chk("disp_held", {8'h00, display_addr}, 32'h111);
    pulse();
    chk("disp_flag1", {8'h00, display_addr}, 32'h222);
    rchk("status_flag1", OFS_STATUS, 32'h3);
    wr(OFS_SYSCTL, 32'h2);
    pulse();
    chk("disp_swapped", {8'h00, display_addr}, 32'h111);
    rchk("status_swapped", OFS_STATUS, 32'h1);
    wr(OFS_SYSCTL, 32'h0);
    q = {16'h2000, 16'h000A, 16'h0014, 16'h3000, 16'hFFFD, 16'h0005, 16'h4000, 16'h0001,
      16'h0002, 16'h5000, 16'h0002, 16'h0003, 16'h1000, 16'h0000, 16'h0000, 16'h0333,
      16'h1000, 16'h0003, 16'h0000, 16'h0001, 16'h0000};
    put(32'h40);
    run(24'h000040);
    rchk("local_offset", OFS_LOCAL_OFS, 32'h0019_0007);
    rchk("cur_ptr", OFS_CUR_PTR, 32'h001E_000A);
    rchk("start_valid", OFS_START_VALID, 32'h1);
    rchk("base_a_cmd", OFS_BASE_A, 32'h333);
    wr(OFS_LOCAL_OFS, 32'hFFFF_FFFF);
    rchk("offset_ro", OFS_LOCAL_OFS, 32'h0019_0007);
    chk("disp_pending", {8'h00, display_addr}, 32'h111);
    pulse();
    chk("disp_cmd_base", {8'h00, display_addr}, 32'h333);
    q = {16'h9001, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'hA006, 16'h0005, 16'h0006,
      16'h0007, 16'h0008, 16'h0000, 16'h0000, 16'h0002, 16'hC123, 16'hC456, 16'h6000,
      16'h0000, 16'h0078, 16'h7000};
    put(32'h60);
    q = {16'h7000, 16'h8000, 16'h0009, 16'h000A, 16'h000B, 16'h000C, 16'h0000};
    put(32'h78);
    run(24'h000060);
    chk("draw_count", mdl.n, 32'h4);
    chk("fill_op", {28'h0, mdl.log_req[0].op}, {28'h0, OP_QUAD_FILL});
    chk("fill_ref", {31'h0, mdl.log_req[0].work_ref}, 32'h1);
    chk("fill_base", {8'h00, mdl.log_req[0].dest_base}, 32'h222);
    chk("fill_no_refill", mdl.log_acks[0], 32'h0);
    chk("tex_op", {28'h0, mdl.log_req[1].op}, {28'h0, OP_QUAD_TEXTURE});
    chk("tex_src", {8'h00, mdl.log_req[1].src_start}, 32'h6D);
    chk("src_word0", {16'h0, mdl.log_src[1][0]}, 32'hC123);
    chk("src_wrap", {16'h0, mdl.log_src[1][1]}, 32'hC456);
    chk("refill_words", mdl.log_acks[1], 32'h10);
    chk("clear_op", {28'h0, mdl.log_req[2].op}, {28'h0, OP_WORK_CLEAR});
    chk("wfill_op", {28'h0, mdl.log_req[3].op}, {28'h0, OP_WORK_FILL});
    chk("wfill_work", {31'h0, mdl.log_req[3].to_work}, 32'h1);
    rchk("cur_ptr_scratch", OFS_CUR_PTR, 32'h000C_000B);
    wrap_up();
  end
endmodule

// file: verif/dlfc_engine_checker.sv
`timescale 1ns/1ps
module dlfc_engine_checker
  import dlfc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic mem_req,
  input wire logic [MEM_AW-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic frame_update,
  input wire logic draw_valid,
  input wire logic draw_ready,
  input wire dlfc_draw_s draw_req,
  input wire logic src_valid,
  input wire logic src_ready,
  input wire logic [MEM_AW-1:0] display_addr
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_WR_RESP: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response missing");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  AST_DISP_HOLD: assert property (!frame_update |=> $stable(display_addr))
    else $error("display address changed without update");
  AST_GO: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready &&
    s_axi_awaddr == OFS_SYSCTL && s_axi_wdata[0] |-> ##[1:3] mem_req)
    else $error("start did not begin fetching");
  AST_MEM_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request not held");
  AST_DRAW_HOLD: assert property (draw_valid && !draw_ready |=>
    draw_valid && $stable(draw_req))
    else $error("draw request not held");
  AST_SRC_PULSE: assert property (src_ready |-> src_valid ##1 !src_ready)
    else $error("source answer malformed");
endmodule

bind dlfc_engine dlfc_engine_checker chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .mem_req, .mem_addr, .mem_ack, .frame_update,
  .draw_valid, .draw_ready, .draw_req, .src_valid, .src_ready, .display_addr);

// file: verif/dlfc_far_model.sv
`timescale 1ns/1ps
module dlfc_far_model
  import dlfc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mem_req,
  input wire logic [MEM_AW-1:0] mem_addr,
  output logic mem_ack,
  output logic [MEM_DW-1:0] mem_rdata,
  input wire logic draw_valid,
  output logic draw_ready,
  input wire dlfc_draw_s draw_req,
  output logic draw_done,
  output logic src_valid,
  output logic [15:0] src_index,
  input wire logic src_ready,
  input wire logic [MEM_DW-1:0] src_data
);
  logic [15:0] mem [256];
  dlfc_draw_s log_req [8];
  logic [15:0] log_src [8][2];
  int log_acks [8];
  int n;
  logic [2:0] st;
  logic slow;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'hC000 | 16'(i);
  end

  // Answers alternate between prompt and late; idle data lines keep toggling.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_ack <= 1'b0;
      slow <= 1'b0;
      mem_rdata <= 16'h0F0F;
    end else begin
      slow <= !slow;
      mem_ack <= mem_req && !mem_ack && slow;
      mem_rdata <= (mem_req && !mem_ack && slow) ? mem[mem_addr[7:0]] : ~mem_rdata;
    end
  end

  // Rasterizer: takes a draw, asks source words 0 and 3 when needed, then reports done.
  always_ff @(posedge aclk) begin
    draw_done <= 1'b0;
    if (!aresetn) begin
      st <= 3'h0;
      n <= 0;
      draw_ready <= 1'b0;
      src_valid <= 1'b0;
      src_index <= 16'h0000;
      for (int i = 0; i < 8; i++) log_acks[i] <= 0;
    end else begin
      if (st != 3'h0 && mem_ack) log_acks[n] <= log_acks[n] + 1;
      case (st)
        3'h0: begin
          draw_ready <= draw_valid && !draw_ready;
          if (draw_valid && draw_ready) begin
            log_req[n] <= draw_req;
            draw_ready <= 1'b0;
            src_valid <= draw_req.use_src;
            src_index <= 16'h0000;
            st <= draw_req.use_src ? 3'h1 : 3'h3;
          end
        end
        3'h1, 3'h2: if (src_ready) begin
          log_src[n][st[1]] <= src_data;
          src_valid <= 1'b0;
          src_index <= ~src_index;
          st <= st + 3'h3;
        end
        3'h4: begin
          src_valid <= 1'b1;
          src_index <= 16'h0003;
          st <= 3'h2;
        end
        default: begin
          draw_done <= 1'b1;
          n <= n + 1;
          st <= 3'h0;
        end
      endcase
    end
  end
endmodule
